// ### hw/mmc_consts.svh
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define MMC_IDX_MODE        8'h0B
`define MMC_IDX_DIRECT      8'h11
`define MMC_IDX_PROG_PAGE   8'h15

// Reset values and field positions
`define MMC_PROG_PAGE_RST   4'hE
`define MMC_MODE_BIT        7
`define MMC_DIRECT_RST      8'h00

// Fixed flash pages of the local map
`define MMC_PAGE_FIX0       4'hC
`define MMC_PAGE_FIX1       4'hD
`define MMC_PAGE_FIX3       4'hF

// Local address decode boundaries
`define MMC_REG_HI          16'h03FF
`define MMC_HOLE_LO         16'h0400
`define MMC_HOLE_HI         16'h07FF
`define MMC_RAM_LO          16'h2000
`define MMC_RAM_HI          16'h3FFF
`define MMC_DBG_LO          16'hFF00
`define MMC_WIN_DBG_LO      16'hBF00
`define MMC_WIN_DBG_HI      16'hBFFF

// Bus answers
`define MMC_RESP_OKAY       2'h0
`define MMC_RESP_SLVERR     2'h2
`define MMC_ZERO8           8'h00
`define MMC_ZERO32          32'h0000_0000

`endif

// ### hw/mmc_pkg.sv
package mmc_pkg;

  typedef enum logic [1:0] {
    MMC_IDLE = 2'b00,
    MMC_BUSY = 2'b01,
    MMC_RESP = 2'b10
  } mmc_fsm_t;

  typedef enum logic [1:0] {
    MMC_SEL_REG   = 2'b00,
    MMC_SEL_RAM   = 2'b01,
    MMC_SEL_FLASH = 2'b10,
    MMC_SEL_DBG   = 2'b11
  } mmc_sel_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } mmc_sync_t;

  typedef struct packed {
    mmc_fsm_t    fsm;
    logic        grant_dbg;
    logic        capture_pending;
    logic        normal_single_chip;
    logic        mode_lock;
    logic        direct_written;
    logic [7:0]  direct_page_bits;
    logic [3:0]  program_page_index;
    logic        background_debug_active;
    logic        tgt_req;
    logic        tgt_we;
    mmc_sel_t    tgt_sel;
    logic [17:0] tgt_addr;
    logic [7:0]  tgt_wdata;
    logic        cpu_ack;
    logic        dbg_ack;
    logic [7:0]  rsp_data;
    logic        sys_reset_req;
    logic        access_refused;
    logic        awready;
    logic        aw_have;
    logic [31:0] awaddr;
    logic        wready;
    logic        w_have;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mmc_state_t;

endpackage

// ### hw/mmc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module mmc_sync2
  import mmc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic d,
  output logic      q
);

  mmc_sync_t st_ff;
  mmc_sync_t nxt_st;

  // No reset on purpose: the pin must keep moving while reset is held
  always_comb begin
    nxt_st.stage1 = d;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign q = st_ff.stage2;

endmodule

`default_nettype wire

// ### hw/mmc_top.sv
// Overview of operation
// - Capture mode pin at reset release
// - Only normal and special single-chip modes exist
// - Special mode enters background debug after reset
// - Core access to unmapped address raises reset
// - Arbitrate core and debug unit accesses
// - Each master has its own address map
// - Page index maps 64 KB onto 256 KB
// - Secured chip refuses external flash access
// - Bad mode write ignored, locks; secured blocks all
// - Direct page write-once in normal mode
// - Direct page supplies core address bits 15:8
// - Program page index resets to page E
`timescale 1ns/1ps
`default_nettype none
`include "mmc_consts.svh"

module mmc_top
  import mmc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mode_select_pin,
  input  wire logic        chip_secured,
  input  wire logic        debug_exit,
  input  wire logic [31:0] s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [31:0] s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic        cpu_direct,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic             cpu_ack,
  output logic [7:0]       cpu_rdata,
  input  wire logic        dbg_req,
  input  wire logic        dbg_we,
  input  wire logic [15:0] dbg_addr,
  input  wire logic [7:0]  dbg_wdata,
  output logic             dbg_ack,
  output logic [7:0]       dbg_rdata,
  output logic             tgt_req,
  output logic             tgt_we,
  output logic [1:0]       tgt_sel,
  output logic [17:0]      tgt_addr,
  output logic [7:0]       tgt_wdata,
  input  wire logic        tgt_ack,
  input  wire logic [7:0]  tgt_rdata,
  output logic             normal_single_chip,
  output logic             background_debug_active,
  output logic [3:0]       program_page_index,
  output logic             sys_reset_req,
  output logic             access_refused
);

  mmc_state_t st_ff;
  mmc_state_t nxt_st;
  logic       pin_sync;

  // Mode pin comes from outside the clock domain
  mmc_sync2 u_mode_sync (
    .aclk (aclk),
    .d    (mode_select_pin),
    .q    (pin_sync)
  );

  // Returns {unmapped, selected target, global address} for one local address
  function automatic logic [20:0] decode(input logic [15:0] a,
                                         input logic        from_dbg,
                                         input logic        dbg_act,
                                         input logic [3:0]  pg);
    logic [3:0] page;
    mmc_sel_t   sel;
    logic       hole;
    unique case (a[15:14])
      2'b00: page = `MMC_PAGE_FIX0;
      2'b01: page = `MMC_PAGE_FIX1;
      2'b10: page = pg;
      2'b11: page = `MMC_PAGE_FIX3;
    endcase
    hole = (a >= `MMC_HOLE_LO) && (a <= `MMC_HOLE_HI);
    if (a <= `MMC_REG_HI) begin
      sel = MMC_SEL_REG;
    end else if ((a >= `MMC_RAM_LO) && (a <= `MMC_RAM_HI)) begin
      sel = MMC_SEL_RAM;
    end else begin
      sel = MMC_SEL_FLASH;
    end
    // Debug resources: top page always seen by the debug unit, by the core only while active; window BF00-BFFF by both only while active with page F
    if ((a >= `MMC_DBG_LO) && (from_dbg || dbg_act)) begin
      sel = MMC_SEL_DBG;
    end
    if (dbg_act && (pg == `MMC_PAGE_FIX3) &&
        (a >= `MMC_WIN_DBG_LO) && (a <= `MMC_WIN_DBG_HI)) begin
      sel = MMC_SEL_DBG;
    end
    decode = {hole, sel, page, a[13:0]};
  endfunction

  logic        use_dbg;
  logic [15:0] loc_addr;
  logic [20:0] dec;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic        wr_hit;
  logic [7:0]  rd_idx;
  logic        rd_hit;
  logic [7:0]  rd_val;

  always_comb begin
    nxt_st = st_ff;
    // One-cycle pulses drop by default
    nxt_st.cpu_ack        = 1'b0;
    nxt_st.dbg_ack        = 1'b0;
    nxt_st.sys_reset_req  = 1'b0;
    nxt_st.access_refused = 1'b0;

    // Mode taken from the synchronised pin in the first cycle after release
    if (st_ff.capture_pending) begin
      nxt_st.capture_pending         = 1'b0;
      nxt_st.normal_single_chip      = pin_sync;
      nxt_st.background_debug_active = ~pin_sync;
    end else if (debug_exit) begin
      nxt_st.background_debug_active = 1'b0;
    end

    // Debug unit wins a tie: it only runs while the core is held
    use_dbg  = dbg_req;
    loc_addr = use_dbg ? dbg_addr :
               (cpu_direct ? {st_ff.direct_page_bits, cpu_addr[7:0]} : cpu_addr);
    dec      = decode(loc_addr, use_dbg, st_ff.background_debug_active,
                      st_ff.program_page_index);

    unique case (st_ff.fsm)
      MMC_IDLE: begin
        if (!st_ff.capture_pending && (dbg_req || cpu_req)) begin
          nxt_st.grant_dbg = use_dbg;
          if (dec[20]) begin
            // Unmapped: core gets a reset, debug unit just reads zero
            nxt_st.rsp_data      = `MMC_ZERO8;
            nxt_st.sys_reset_req = ~use_dbg;
            nxt_st.cpu_ack       = ~use_dbg;
            nxt_st.dbg_ack       = use_dbg;
            nxt_st.fsm           = MMC_RESP;
          end else if (use_dbg && chip_secured && (mmc_sel_t'(dec[19:18]) == MMC_SEL_FLASH)) begin
            nxt_st.rsp_data       = `MMC_ZERO8;
            nxt_st.access_refused = 1'b1;
            nxt_st.dbg_ack        = 1'b1;
            nxt_st.fsm            = MMC_RESP;
          end else begin
            nxt_st.tgt_req   = 1'b1;
            nxt_st.tgt_we    = use_dbg ? dbg_we : cpu_we;
            nxt_st.tgt_wdata = use_dbg ? dbg_wdata : cpu_wdata;
            nxt_st.tgt_sel   = mmc_sel_t'(dec[19:18]);
            nxt_st.tgt_addr  = dec[17:0];
            nxt_st.fsm       = MMC_BUSY;
          end
        end
      end
      MMC_BUSY: begin
        if (tgt_ack) begin
          nxt_st.tgt_req  = 1'b0;
          nxt_st.rsp_data = tgt_rdata;
          nxt_st.cpu_ack  = ~st_ff.grant_dbg;
          nxt_st.dbg_ack  = st_ff.grant_dbg;
          nxt_st.fsm      = MMC_RESP;
        end
      end
      MMC_RESP: begin
        // Gap cycle lets the master drop its request after the ack
        nxt_st.fsm = MMC_IDLE;
      end
      default: begin
        nxt_st.fsm     = MMC_IDLE;
        nxt_st.tgt_req = 1'b0;
      end
    endcase

    // Write address and data are taken in either order
    if (st_ff.awready && s_axil_awvalid) begin
      nxt_st.awready = 1'b0;
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = s_axil_awaddr;
    end
    if (st_ff.wready && s_axil_wvalid) begin
      nxt_st.wready = 1'b0;
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = s_axil_wdata[7:0];
      nxt_st.wstrb0 = s_axil_wstrb[0];
    end

    wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    wr_idx  = st_ff.awaddr[9:2];
    wr_hit  = (st_ff.awaddr[31:10] == 22'h000000) && (st_ff.awaddr[1:0] == 2'h0) &&
              ((wr_idx == `MMC_IDX_MODE) || (wr_idx == `MMC_IDX_DIRECT) ||
               (wr_idx == `MMC_IDX_PROG_PAGE));
    if (wr_fire) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_hit ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
      if (wr_hit && st_ff.wstrb0) begin
        if (wr_idx == `MMC_IDX_MODE) begin
          // Only special to normal is allowed; the reverse locks the bit
          if (!chip_secured && !(st_ff.normal_single_chip && st_ff.mode_lock)) begin
            if (!st_ff.normal_single_chip && st_ff.wdata[`MMC_MODE_BIT]) begin
              nxt_st.normal_single_chip = 1'b1;
            end else if (st_ff.normal_single_chip && !st_ff.wdata[`MMC_MODE_BIT]) begin
              nxt_st.mode_lock = 1'b1;
            end
          end
        end else if (wr_idx == `MMC_IDX_DIRECT) begin
          if (!st_ff.normal_single_chip || !st_ff.direct_written) begin
            nxt_st.direct_page_bits = st_ff.wdata;
            nxt_st.direct_written   = 1'b1;
          end
        end else begin
          nxt_st.program_page_index = st_ff.wdata[3:0];
        end
      end
    end
    if (st_ff.bvalid && s_axil_bready) begin
      nxt_st.bvalid  = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready  = 1'b1;
    end

    // Reads answer one cycle after the address is taken
    rd_idx = s_axil_araddr[9:2];
    rd_hit = (s_axil_araddr[31:10] == 22'h000000) && (s_axil_araddr[1:0] == 2'h0);
    if (rd_idx == `MMC_IDX_MODE) begin
      rd_val = {st_ff.normal_single_chip, 7'h00};
    end else if (rd_idx == `MMC_IDX_DIRECT) begin
      rd_val = st_ff.direct_page_bits;
    end else if (rd_idx == `MMC_IDX_PROG_PAGE) begin
      rd_val = {4'h0, st_ff.program_page_index};
    end else begin
      rd_val = `MMC_ZERO8;
      rd_hit = 1'b0;
    end
    if (st_ff.arready && s_axil_arvalid) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid  = 1'b1;
      nxt_st.rdata   = {24'h000000, rd_val};
      nxt_st.rresp   = rd_hit ? `MMC_RESP_OKAY : `MMC_RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axil_rready) begin
      nxt_st.rvalid  = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  // Synchronous reset; mode is re-captured after every release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff                         <= '0;
      st_ff.fsm                     <= MMC_IDLE;
      st_ff.capture_pending         <= 1'b1;
      st_ff.direct_page_bits        <= `MMC_DIRECT_RST;
      st_ff.program_page_index      <= `MMC_PROG_PAGE_RST;
      st_ff.awready                 <= 1'b1;
      st_ff.wready                  <= 1'b1;
      st_ff.arready                 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axil_awready          = st_ff.awready;
  assign s_axil_wready           = st_ff.wready;
  assign s_axil_bresp            = st_ff.bresp;
  assign s_axil_bvalid           = st_ff.bvalid;
  assign s_axil_arready          = st_ff.arready;
  assign s_axil_rdata            = st_ff.rdata;
  assign s_axil_rresp            = st_ff.rresp;
  assign s_axil_rvalid           = st_ff.rvalid;
  assign cpu_ack                 = st_ff.cpu_ack;
  assign cpu_rdata               = st_ff.rsp_data;
  assign dbg_ack                 = st_ff.dbg_ack;
  assign dbg_rdata               = st_ff.rsp_data;
  assign tgt_req                 = st_ff.tgt_req;
  assign tgt_we                  = st_ff.tgt_we;
  assign tgt_sel                 = st_ff.tgt_sel;
  assign tgt_addr                = st_ff.tgt_addr;
  assign tgt_wdata               = st_ff.tgt_wdata;
  assign normal_single_chip      = st_ff.normal_single_chip;
  assign background_debug_active = st_ff.background_debug_active;
  assign program_page_index      = st_ff.program_page_index;
  assign sys_reset_req           = st_ff.sys_reset_req;
  assign access_refused          = st_ff.access_refused;

endmodule

`default_nettype wire

// ### testbench/mmc_checker.sv
`timescale 1ns/1ps
`default_nettype none

module mmc_checker
  import mmc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        mode_select_pin,
  input wire logic        cpu_ack,
  input wire logic        dbg_ack,
  input wire logic [7:0]  cpu_rdata,
  input wire logic [7:0]  dbg_rdata,
  input wire logic        tgt_req,
  input wire logic        tgt_ack,
  input wire logic [1:0]  tgt_sel,
  input wire logic [17:0] tgt_addr,
  input wire logic        normal_single_chip,
  input wire logic        background_debug_active,
  input wire logic [3:0]  program_page_index,
  input wire logic        sys_reset_req,
  input wire logic        access_refused
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Mode follows the pin on the first edge out of reset
  a_mode_capture: assert property ($past(aresetn) && !$past(aresetn, 2) |->
    normal_single_chip == mode_select_pin && background_debug_active != mode_select_pin)
    else $error("mode not taken from pin");
  a_page_reset: assert property (!$past(aresetn) |-> program_page_index == 4'hE)
    else $error("page index reset value wrong");
  // One master answered at a time, for one cycle
  a_ack_single: assert property (!(cpu_ack && dbg_ack))
    else $error("both masters answered");
  a_ack_pulse: assert property (cpu_ack || dbg_ack |=> !(cpu_ack || dbg_ack))
    else $error("answer longer than one cycle");
  // Target request is held until the target answers
  a_tgt_hold: assert property (tgt_req && !tgt_ack && !$past(tgt_ack) |=>
    tgt_req && $stable(tgt_addr) && $stable(tgt_sel))
    else $error("target request not held");
  a_tgt_answer: assert property (tgt_req && tgt_ack |-> ##[1:2] (cpu_ack || dbg_ack))
    else $error("no answer after target ack");
  // Refusals answer with zero data; only the debug refusal is also checked for no target traffic
  a_reset_core: assert property (sys_reset_req |-> cpu_ack && cpu_rdata == 8'h00)
    else $error("reset request without core answer");
  a_refuse_dbg: assert property (access_refused |->
    dbg_ack && dbg_rdata == 8'h00 && !tgt_req)
    else $error("refusal not clean");
  // RAM lives in fixed page C, debug resources in the top 256 bytes
  a_ram_page: assert property (tgt_req && tgt_sel == MMC_SEL_RAM |->
    tgt_addr[17:13] == 5'h19)
    else $error("RAM access outside its page");
  a_dbg_window: assert property (tgt_req && tgt_sel == MMC_SEL_DBG |->
    tgt_addr[17:8] == 10'h3FF)
    else $error("debug access outside window");
  cover property (sys_reset_req);
  cover property (access_refused);
  cover property (tgt_req && tgt_sel == MMC_SEL_DBG);
endmodule

bind mmc_top mmc_checker chk (.*);

`default_nettype wire

// ### testbench/mmc_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none

module mmc_tgt_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  lat,
  input  wire logic        tgt_req,
  input  wire logic        tgt_we,
  input  wire logic [17:0] tgt_addr,
  input  wire logic [7:0]  tgt_wdata,
  output var logic         tgt_ack = 1'h0,
  output var logic [7:0]   tgt_rdata = 8'h5A
);
  // Keeps only the last byte written: enough for one write-then-read check
  logic [17:0] wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_seen = 1'h0;
  logic [3:0]  cnt;
  logic        done;

  // Answers after lat wait cycles; data is scrambled outside the answer cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      tgt_ack <= 1'h0;
      cnt <= 4'h0;
      done <= 1'h0;
    end else if (tgt_ack) begin
      tgt_ack <= 1'h0;
      done <= 1'h1;
      tgt_rdata <= ~tgt_rdata;
    end else if (tgt_req && !done) begin
      if (cnt == lat) begin
        tgt_ack <= 1'h1;
        cnt <= 4'h0;
        if (tgt_we) begin
          wr_addr <= tgt_addr;
          wr_byte <= tgt_wdata;
          wr_seen <= 1'h1;
        end
        tgt_rdata <= (wr_seen && (wr_addr == tgt_addr)) ? wr_byte : tgt_addr[7:0];
      end else cnt <= cnt + 4'h1;
    end else if (!tgt_req) done <= 1'h0;
  end
endmodule

`default_nettype wire

// ### testbench/mmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmc_consts.svh"

module mmc_top_tb;
  import mmc_pkg::*;
  logic        aclk, aresetn = 1'h0, mode_select_pin = 1'h1, chip_secured = 1'h0;
  logic        debug_exit = 1'h0, cpu_req = 1'h0, cpu_we = 1'h0, cpu_direct = 1'h0;
  logic        dbg_req = 1'h0, dbg_we = 1'h0, s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0;
  logic        s_axil_bready = 1'h0, s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
  logic [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0, s_axil_rdata, d;
  logic [15:0] cpu_addr = '0, dbg_addr = '0;
  logic [7:0]  cpu_wdata = '0, dbg_wdata = '0, cpu_rdata, dbg_rdata, tgt_wdata, tgt_rdata, rv;
  logic [3:0]  s_axil_wstrb = '0, lat = '0, program_page_index;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic        cpu_ack, dbg_ack, tgt_req, tgt_we, tgt_ack, normal_single_chip;
  logic        background_debug_active, sys_reset_req, access_refused, rst_seen, ref_seen;
  logic [1:0]  s_axil_bresp, s_axil_rresp, tgt_sel, gs, rsp;
  logic [17:0] tgt_addr, ga;
  int          n_mismatch = 0, num_checks = 0;

  mmc_top dut (.*);
  mmc_tgt_model tgt (.*);

  // 125 MHz clock
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Pin is set as reset is asserted, so the synchroniser is full at release
  task automatic rst(input logic p);
    aresetn <= 1'h0;
    mode_select_pin <= p;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    cmp({normal_single_chip, background_debug_active}, {p, ~p});
    cmp(program_page_index, 4'hE);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    s_axil_awaddr <= {22'h0, idx, 2'h0};
    s_axil_wdata <= {24'h0, v};
    s_axil_wstrb <= 4'hF;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (s_axil_awready !== 1'h1);
        s_axil_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (s_axil_wready !== 1'h1);
        s_axil_wvalid <= 1'h0;
      end
    join
    // Raised only now, so a following call never raises it in the step this one drops it
    s_axil_bready <= 1'h1;
    do @(posedge aclk); while (s_axil_bvalid !== 1'h1);
    rsp = s_axil_bresp;
    s_axil_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] idx);
    s_axil_araddr <= {22'h0, idx, 2'h0};
    s_axil_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axil_arready !== 1'h1);
    s_axil_arvalid <= 1'h0;
    s_axil_rready <= 1'h1;
    do @(posedge aclk); while (s_axil_rvalid !== 1'h1);
    d = s_axil_rdata;
    rsp = s_axil_rresp;
    s_axil_rready <= 1'h0;
  endtask

  // Byte access by core (m=0) or debug unit; spacing keeps two cycles
  task automatic acc(input logic m, input logic we, input logic dir, input logic [15:0] a,
                     input logic [7:0] wd);
    ga = 'x;
    gs = 'x;
    if (m) begin
      dbg_req <= 1'h1;
      dbg_we <= we;
      dbg_addr <= a;
      dbg_wdata <= wd;
    end else begin
      cpu_req <= 1'h1;
      cpu_we <= we;
      cpu_direct <= dir;
      cpu_addr <= a;
      cpu_wdata <= wd;
    end
    do begin
      @(posedge aclk);
      if (tgt_req === 1'h1) begin
        ga = tgt_addr;
        gs = tgt_sel;
      end
    end while ((m ? dbg_ack : cpu_ack) !== 1'h1);
    rv = m ? dbg_rdata : cpu_rdata;
    rst_seen = sys_reset_req;
    ref_seen = access_refused;
    cpu_req <= 1'h0;
    dbg_req <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_normal;
    rd(`MMC_IDX_PROG_PAGE);
    cmp(d, 32'hE);
    cmp(rsp, `MMC_RESP_OKAY);
    wr(`MMC_IDX_DIRECT, 8'h30);
    cmp(rsp, `MMC_RESP_OKAY);
    wr(`MMC_IDX_DIRECT, 8'h40);
    rd(`MMC_IDX_DIRECT);
    cmp(d, 32'h30);
    wr(`MMC_IDX_MODE, 8'h00);
    rd(`MMC_IDX_MODE);
    cmp({normal_single_chip, d[7:0]}, 9'h180);
    acc(1'h0, 1'h0, 1'h0, 16'h0500, 8'h00);
    cmp({rst_seen, rv}, 9'h100);
    rd(8'h3F);
    cmp(rsp, `MMC_RESP_SLVERR);
    wr(8'h3F, 8'h11);
    cmp(rsp, `MMC_RESP_SLVERR);
  endtask

  task automatic t_special;
    wr(`MMC_IDX_DIRECT, 8'h20);
    wr(`MMC_IDX_DIRECT, 8'h21);
    rd(`MMC_IDX_DIRECT);
    cmp(d, 32'h21);
    acc(1'h0, 1'h1, 1'h1, 16'h0034, 8'h5A);
    cmp(ga, 18'h32134);
    acc(1'h0, 1'h0, 1'h0, 16'h2134, 8'h00);
    cmp(rv, 8'h5A);
    wr(`MMC_IDX_PROG_PAGE, 8'h05);
    acc(1'h0, 1'h0, 1'h0, 16'h8123, 8'h00);
    cmp({gs, ga, rv}, {MMC_SEL_FLASH, 18'h14123, 8'h23});
    acc(1'h0, 1'h0, 1'h0, 16'hC001, 8'h00);
    cmp(ga, 18'h3C001);
    acc(1'h1, 1'h0, 1'h0, 16'hFF10, 8'h00);
    cmp(gs, MMC_SEL_DBG);
    debug_exit <= 1'h1;
    @(posedge aclk);
    debug_exit <= 1'h0;
    @(posedge aclk);
    acc(1'h0, 1'h0, 1'h0, 16'hFF10, 8'h00);
    cmp({gs, ga}, {MMC_SEL_FLASH, 18'h3FF10});
    acc(1'h1, 1'h0, 1'h0, 16'h0500, 8'h00);
    cmp({rst_seen, rv}, 9'h0);
  endtask

  task automatic t_secure;
    chip_secured <= 1'h1;
    acc(1'h1, 1'h0, 1'h0, 16'h8012, 8'h00);
    cmp({ref_seen, rv}, 9'h100);
    acc(1'h0, 1'h0, 1'h0, 16'h8012, 8'h00);
    cmp({ref_seen, rv}, 9'h012);
    wr(`MMC_IDX_MODE, 8'h80);
    rd(`MMC_IDX_MODE);
    cmp(d, 32'h0);
    chip_secured <= 1'h0;
    wr(`MMC_IDX_MODE, 8'h80);
    rd(`MMC_IDX_MODE);
    cmp({normal_single_chip, d[7:0]}, 9'h180);
  endtask

  // Both masters ask at once; debug unit is served first
  task automatic t_arb;
    cpu_req <= 1'h1;
    cpu_we <= 1'h0;
    cpu_direct <= 1'h0;
    cpu_addr <= 16'h2001;
    dbg_req <= 1'h1;
    dbg_we <= 1'h0;
    dbg_addr <= 16'h2002;
    do @(posedge aclk); while (cpu_ack !== 1'h1 && dbg_ack !== 1'h1);
    cmp({dbg_ack, cpu_ack, dbg_rdata}, 10'h202);
    dbg_req <= 1'h0;
    do @(posedge aclk); while (cpu_ack !== 1'h1);
    cmp(cpu_rdata, 8'h01);
    cpu_req <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    rst(1'h1);
    t_normal;
    lat <= 4'h4;
    rst(1'h0);
    t_special;
    t_secure;
    t_arb;
    end_of_test;
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
endmodule

`default_nettype wire
